// ===== exact_freq_synth_control.sv
// digital control of the exact-frequency fractional-N synthesizer
// Functional notes
// - exact steps keep the full 24-bit accumulator modulus, never a shortened one.
// - channel change needs only a new fractional value, honoured exactly.
// - 24-bit seed sets start phase, only while exact operation is active.
// - in exact operation, each new fractional frequency reloads the seed without host action.
// - power-on reset restores all registers after about 250 us.
// - a write to register zero soft resets the control registers.
// - with pin control selected, low chip enable powers down every block not kept on by power bits 2 to 7.
// - with pin control cleared, power-down follows power register bit 1.
// - register writes and reads keep working while powered down.
// - power bits 2 to 7 each keep one block on during power down.
// - integer register holds 19 bits, fractional register 24 bits.
`timescale 1ns/1ps
`include "synth_ctrl_params.svh"
module exact_freq_synth_control #(
  parameter int          POR_CYCLES = `POR_CYCLES,
  parameter logic [23:0] CHIP_ID    = `CHIP_ID_DEFAULT // arbitrary value
) (
  // clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_arst_n,
  // decoded serial port access
  input  wire synth_ctrl_pkg::reg_wr_t  i_wr,
  input  wire logic [4:0]               i_rd_addr,
  output logic [23:0]                   o_rd_data,
  // chip enable pin
  input  wire logic                     i_chip_power_enable_pin,
  // synthesizer controls
  output logic                          o_por_done,
  output logic                          o_power_down,
  output synth_ctrl_pkg::blk_en_t       o_blk_en,
  output logic [18:0]                   o_int_div,
  output logic [23:0]                   o_fractional_phase_accumulator,
  output logic                          o_carry,
  output logic                          o_exact_active
);
  // reset release through two flops
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // chip enable pin: three flops, level accepted once stages two and three agree
  logic cen_s1_reg, cen_s2_reg, cen_s3_reg, cen_reg;
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cen_s1_reg <= 1'b0;
      cen_s2_reg <= 1'b0;
      cen_s3_reg <= 1'b0;
      cen_reg    <= 1'b0;
    end else begin
      cen_s1_reg <= i_chip_power_enable_pin;
      cen_s2_reg <= cen_s1_reg;
      cen_s3_reg <= cen_s2_reg;
      if (cen_s2_reg == cen_s3_reg) cen_reg <= cen_s3_reg;
    end
  end

  // power-on wait; registers sit at defaults and writes are dropped meanwhile
  synth_ctrl_pkg::por_state_t por_state_reg;
  logic [15:0]                por_cnt_reg;
  wire  por_last = (por_cnt_reg == 16'(POR_CYCLES - 1));
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      por_state_reg <= synth_ctrl_pkg::POR_WAIT;
      por_cnt_reg   <= 16'h0000;
    end else begin
      case (por_state_reg)
        synth_ctrl_pkg::POR_WAIT: begin
          por_cnt_reg <= por_cnt_reg + 16'h0001;
          if (por_last) por_state_reg <= synth_ctrl_pkg::RUNNING;
        end
        default: por_state_reg <= synth_ctrl_pkg::RUNNING;
      endcase
    end
  end
  wire running = (por_state_reg == synth_ctrl_pkg::RUNNING);

  // write decode; accepted whatever the power state
  function automatic logic wr_hit(synth_ctrl_pkg::reg_wr_t wr, logic [4:0] addr);
    wr_hit = wr.stb && (wr.addr == addr);
  endfunction
  wire wr_ok     = running;
  wire soft_rst  = wr_ok && wr_hit(i_wr, `ADDR_SOFT_RESET);
  wire wr_power  = wr_ok && wr_hit(i_wr, `ADDR_POWER);
  wire wr_int    = wr_ok && wr_hit(i_wr, `ADDR_INTEGER);
  wire wr_frac   = wr_ok && wr_hit(i_wr, `ADDR_FRACTIONAL);
  wire wr_step   = wr_ok && wr_hit(i_wr, `ADDR_EXACT_STEP);
  wire wr_seed   = wr_ok && wr_hit(i_wr, `ADDR_SEED);

  // control registers
  logic [7:0]  power_reg;
  logic [18:0] int_reg;
  logic [23:0] frac_reg, step_reg, seed_reg;
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      power_reg <= `RST_POWER;
      int_reg   <= `RST_INTEGER;
      frac_reg  <= `RST_FRACTIONAL;
      step_reg  <= `RST_EXACT_STEP;
      seed_reg  <= `RST_SEED;
    end else if (soft_rst || !running) begin
      power_reg <= `RST_POWER;
      int_reg   <= `RST_INTEGER;
      frac_reg  <= `RST_FRACTIONAL;
      step_reg  <= `RST_EXACT_STEP;
      seed_reg  <= `RST_SEED;
    end else begin
      if (wr_power) power_reg <= i_wr.data[7:0];
      if (wr_int)   int_reg   <= i_wr.data[18:0];
      if (wr_frac)  frac_reg  <= i_wr.data;
      if (wr_step)  step_reg  <= i_wr.data;
      if (wr_seed)  seed_reg  <= i_wr.data;
    end
  end

  // power-down source selection and per-block keep-on
  wire pd_next = power_reg[`PWR_PIN_SEL_BIT] ? !cen_reg
                                             : power_reg[`PWR_SW_DOWN_BIT];
  wire [5:0] keep = power_reg[7:`PWR_KEEP_LSB];
  wire [5:0] blk_next = {6{!pd_next}} | keep;
  logic                    pd_reg;
  synth_ctrl_pkg::blk_en_t blk_reg;
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pd_reg  <= 1'b1;
      blk_reg <= '0;
    end else begin
      pd_reg  <= pd_next;
      blk_reg <= blk_next;
    end
  end

  // phase accumulator: always modulo 2^24; exact mode resyncs to the seed
  // every exact-step period, when the ideal phase is back at its start
  wire        exact_next = (step_reg != 24'h000000);
  logic       exact_reg;
  logic [23:0] acc_reg, step_cnt_reg;
  logic        carry_reg;
  wire [24:0] sum        = {1'b0, acc_reg} + {1'b0, frac_reg};
  wire        period_end = (step_cnt_reg == step_reg - 24'h000001);
  wire        reload     = exact_reg && (wr_frac || soft_rst);
  wire [23:0] acc_next   = reload                 ? seed_reg :
                           pd_reg                 ? acc_reg :
                           (exact_reg && period_end) ? seed_reg :
                           sum[23:0];
  wire [23:0] cnt_next   = (reload || period_end || !exact_reg) ? 24'h000000 :
                           pd_reg ? step_cnt_reg : step_cnt_reg + 24'h000001;
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      exact_reg    <= 1'b0;
      acc_reg      <= 24'h000000;
      step_cnt_reg <= 24'h000000;
      carry_reg    <= 1'b0;
    end else begin
      exact_reg    <= exact_next;
      acc_reg      <= acc_next;
      step_cnt_reg <= (pd_reg && !reload) ? step_cnt_reg : cnt_next;
      carry_reg    <= !pd_reg && !reload && sum[24]; // internal clocks stop in power down
    end
  end

  // read port; register zero shows the identity code
  wire [23:0] rd_next = (i_rd_addr == `ADDR_SOFT_RESET) ? CHIP_ID :
                        (i_rd_addr == `ADDR_POWER)      ? {16'h0000, power_reg} :
                        (i_rd_addr == `ADDR_INTEGER)    ? {5'h00, int_reg} :
                        (i_rd_addr == `ADDR_FRACTIONAL) ? frac_reg :
                        (i_rd_addr == `ADDR_EXACT_STEP) ? step_reg :
                        (i_rd_addr == `ADDR_SEED)       ? seed_reg : 24'h000000;
  logic [23:0] rd_reg;
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) rd_reg <= 24'h000000;
    else            rd_reg <= rd_next;
  end

  // outputs straight from flops
  assign o_rd_data                      = rd_reg;
  assign o_por_done                     = running;
  assign o_power_down                   = pd_reg;
  assign o_blk_en                       = blk_reg;
  assign o_int_div                      = int_reg;
  assign o_fractional_phase_accumulator = acc_reg;
  assign o_carry                        = carry_reg;
  assign o_exact_active                 = exact_reg;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n_reg);
  seed_reload_a: assert property (wr_frac && exact_reg |=> acc_reg == $past(seed_reg))
    else $error("seed not reloaded on fractional write");
  seed_exact_only_a: assert property (wr_frac && !exact_reg && !pd_reg |=> acc_reg == $past(sum[23:0]))
    else $error("seed applied outside exact mode");
  soft_reset_a: assert property (soft_rst |=> power_reg == `RST_POWER && frac_reg == `RST_FRACTIONAL)
    else $error("soft reset left registers");
  pin_power_a: assert property (power_reg[0] && !cen_reg |=> pd_reg)
    else $error("pin low did not power down");
  sw_power_a: assert property (!power_reg[0] |=> pd_reg == $past(power_reg[1]))
    else $error("software power-down ignored");
  keep_on_a: assert property (pd_reg |-> blk_reg == $past(keep))
    else $error("keep-on bits not honoured");
  write_in_pd_a: assert property (pd_reg && wr_int |=> int_reg == $past(i_wr.data[18:0]))
    else $error("write lost in power down");
  full_modulus_a: assert property (!pd_reg && !exact_reg && !wr_frac && !soft_rst
                                   |=> acc_reg == $past(sum[23:0]) && carry_reg == $past(sum[24]))
    else $error("accumulator not modulo 2^24");
  por_hold_a: assert property (!running |-> power_reg == `RST_POWER && frac_reg == `RST_FRACTIONAL)
    else $error("registers moved during power-on wait");
  channel_hold_a: assert property (wr_frac |=> $stable(int_reg) && $stable(step_reg))
    else $error("fractional write disturbed integer or step");
  pd_freeze_a: assert property (pd_reg && !reload |=> $stable(acc_reg))
    else $error("accumulator ran in power down");
  cv_exact_reload_c: cover property (exact_reg && wr_frac);
  cv_period_c: cover property (exact_reg && period_end && !pd_reg);
  cv_pin_down_c: cover property (power_reg[0] && $fell(cen_reg));
  cv_soft_reset_c: cover property (soft_rst);
endmodule

// ===== synth_ctrl_params.svh
// register offsets, reset values and timing counts of the synthesizer control block
`ifndef SYNTH_CTRL_PARAMS_SVH
`define SYNTH_CTRL_PARAMS_SVH
`define ADDR_SOFT_RESET   5'h00
`define ADDR_POWER        5'h01
`define ADDR_INTEGER      5'h03
`define ADDR_FRACTIONAL   5'h04
`define ADDR_EXACT_STEP   5'h0C
`define ADDR_SEED         5'h1A
`define PWR_PIN_SEL_BIT   0
`define PWR_SW_DOWN_BIT   1
`define PWR_KEEP_LSB      2
`define RST_POWER         8'h01
`define RST_INTEGER       19'h00014
`define RST_FRACTIONAL    24'h000000
`define RST_EXACT_STEP    24'h000000
`define RST_SEED          24'h000000
`define CHIP_ID_DEFAULT   24'h5A3C01
`define CLK_PERIOD_NS     40
`define POR_TIME_NS       250000
`define POR_CYCLES        ((`POR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== synth_ctrl_pkg.sv
// types shared by the synthesizer control block
package synth_ctrl_pkg;
  // one decoded register write from the serial port
  typedef struct packed {
    logic        stb;
    logic [4:0]  addr;
    logic [23:0] data;
  } reg_wr_t;
  // per-block power enables
  typedef struct packed {
    logic test_pads;
    logic vco_buf;
    logic ref_buf;
    logic charge_pump;
    logic phase_detector;
    logic bias;
  } blk_en_t;
  typedef enum logic {POR_WAIT, RUNNING} por_state_t;
endpackage

// ===== synth_host_model.sv
// host-side model that issues register writes and reads to the control block
`timescale 1ns/1ps
module synth_host_model (
  // clock
  input  wire logic                    i_clk,
  // register access toward the block
  output synth_ctrl_pkg::reg_wr_t      o_wr,
  output logic [4:0]                   o_rd_addr,
  input  wire logic [23:0]             i_rd_data
);
  // idle at time zero so no write is seen before the first request
  initial begin
    o_wr      = '0;
    o_rd_addr = 5'h1F;
  end
  // one-cycle strobe; released data is inverted so stale values never look valid
  task automatic wr(input logic [4:0] addr, input logic [23:0] data);
    @(posedge i_clk);
    o_wr <= '{stb: 1'b1, addr: addr, data: data};
    @(posedge i_clk);
    o_wr <= '{stb: 1'b0, addr: ~addr, data: ~data};
  endtask
  // read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [4:0] addr, output logic [23:0] data);
    @(posedge i_clk);
    o_rd_addr <= addr;
    @(posedge i_clk);
    #1;
    data = i_rd_data;
  endtask
endmodule

// ===== tb_exact_freq_synth_control.sv
// self-checking testbench of the synthesizer control block
`timescale 1ns/1ps
`include "synth_ctrl_params.svh"
module tb_exact_freq_synth_control;
  localparam logic [23:0] TB_ID = 24'h3C96A5; // arbitrary identity value
  localparam logic [23:0] SEED  = 24'h123457;
  logic                    clk;
  logic                    arst_n;
  logic                    pin;
  synth_ctrl_pkg::reg_wr_t wr;
  logic [4:0]              rd_addr;
  logic [23:0]             rd_data;
  logic                    por_done;
  logic                    pdown;
  logic                    carry;
  logic                    exact;
  logic                    c;
  synth_ctrl_pkg::blk_en_t blk_en;
  logic [18:0]             int_div;
  logic [23:0]             acc;
  logic [23:0]             v;
  logic [23:0]             e;
  int                      failures;
  int                      n_tests;

  exact_freq_synth_control #(.POR_CYCLES(8), .CHIP_ID(TB_ID)) DUT (
    .i_clk(clk), .i_arst_n(arst_n), .i_wr(wr), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
    .i_chip_power_enable_pin(pin), .o_por_done(por_done), .o_power_down(pdown), .o_blk_en(blk_en),
    .o_int_div(int_div), .o_fractional_phase_accumulator(acc), .o_carry(carry), .o_exact_active(exact));
  synth_host_model host (.i_clk(clk), .o_wr(wr), .o_rd_addr(rd_addr), .i_rd_data(rd_data));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [23:0] exp);
    host.rd(a, v);
    chk(v, exp);
  endtask
  // defaults shared by power-on and soft reset
  task automatic check_defaults();
    rchk(`ADDR_POWER, {16'h0000, `RST_POWER});
    rchk(`ADDR_INTEGER, {5'h00, `RST_INTEGER});
    rchk(`ADDR_FRACTIONAL, `RST_FRACTIONAL);
    rchk(`ADDR_EXACT_STEP, `RST_EXACT_STEP);
    rchk(`ADDR_SEED, `RST_SEED);
    chk({5'h00, int_div}, {5'h00, `RST_INTEGER});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the roughly 130 cycles the tests need
  initial begin
    #(40 * 3000);
    failures++;
    conclude();
  end

  initial begin
    arst_n = 1'b0;
    pin = 1'b1;
    failures = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk); // internal reset gone, power-on wait still running
    host.wr(`ADDR_INTEGER, 24'h00002D); // lands inside the power-on wait, so dropped
    #1 chk({23'h0, por_done}, 24'h000000);
    for (int i = 0; i < 40 && por_done !== 1'b1; i++) @(posedge clk);
    chk({23'h0, por_done}, 24'h000001);
    check_defaults();
    rchk(`ADDR_SOFT_RESET, TB_ID);
    host.wr(5'h02, 24'hFFFFFF); // unmapped place stays empty
    rchk(5'h02, 24'h000000);
    host.wr(`ADDR_INTEGER, 24'hFFFFFF);
    rchk(`ADDR_INTEGER, 24'h07FFFF);
    chk({5'h00, int_div}, 24'h07FFFF);
    // step still zero: a new fraction must not load the seed
    host.wr(`ADDR_SEED, SEED); // non-zero, non-binary start phase
    host.wr(`ADDR_FRACTIONAL, 24'h400000);
    #1 chk(acc, 24'h000000);
    @(posedge clk);
    #1 chk(acc, 24'h400000);
    // 20 kHz gcd beats rate over 2^24 for two adjacent channels
    host.wr(`ADDR_INTEGER, 24'h00002D); // floor of target over rate
    host.wr(`ADDR_EXACT_STEP, 24'h000C00); // rate over gcd
    host.wr(`ADDR_FRACTIONAL, 24'h938000); // ceiling of scaled offset
    #1 chk(acc, SEED);
    chk({23'h0, exact}, 24'h000001);
    host.wr(`ADDR_FRACTIONAL, 24'h93EAAB); // next channel, fraction only
    #1 chk(acc, SEED);
    rchk(`ADDR_FRACTIONAL, 24'h93EAAB);
    rchk(`ADDR_EXACT_STEP, 24'h000C00);
    // four steps of a quarter turn wrap exactly on the full 24-bit modulus
    host.wr(`ADDR_EXACT_STEP, 24'h000004);
    host.wr(`ADDR_FRACTIONAL, 24'h400000);
    e = SEED;
    #1 chk(acc, e);
    for (int k = 1; k < 13; k++) begin
      @(posedge clk);
      #1;
      {c, e} = {1'b0, e} + 25'h0400000;
      chk(acc, e);
      chk({23'h0, carry}, {23'h0, c});
    end
    host.wr(`ADDR_SOFT_RESET, 24'hFFFFFF);
    check_defaults();
    chk({23'h0, exact}, 24'h000000);
    // pin control: low pin powers down and freezes the accumulator
    host.wr(`ADDR_FRACTIONAL, 24'h000123);
    @(posedge clk);
    pin <= 1'b0;
    for (int i = 0; i < 10 && pdown !== 1'b1; i++) @(posedge clk);
    #1 chk({23'h0, pdown}, 24'h000001);
    chk({18'h0, blk_en}, 24'h000000);
    v = acc;
    repeat (3) @(posedge clk);
    #1 chk(acc, v);
    host.wr(`ADDR_SEED, SEED);
    rchk(`ADDR_SEED, SEED);
    host.wr(`ADDR_INTEGER, 24'h00002D);
    rchk(`ADDR_INTEGER, 24'h00002D);
    pin <= 1'b1;
    for (int i = 0; i < 10 && pdown !== 1'b0; i++) @(posedge clk);
    #1 chk({23'h0, pdown}, 24'h000000);
    chk({18'h0, blk_en}, 24'h00003F);
    // register control: the pin no longer matters
    host.wr(`ADDR_POWER, 24'h000000);
    pin <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk({23'h0, pdown}, 24'h000000);
    for (int i = 0; i < 6; i++) begin
      host.wr(`ADDR_POWER, 24'h000002 | (24'h000004 << i));
      @(posedge clk);
      #1 chk({23'h0, pdown}, 24'h000001);
      chk({18'h0, blk_en}, 24'h000001 << i);
    end
    rchk(`ADDR_POWER, 24'h000082);
    conclude();
  end
endmodule
